// ===== common/als_pkg.sv
`default_nettype none
package als_pkg;

    // data width of monitored quantities, thresholds and the output word
    localparam int ALS_DW = 8;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] ALS_IDX_SELECT = 8'h1E;
    localparam logic [7:0] ALS_IDX_LVL1 = 8'h1F;
    localparam logic [7:0] ALS_IDX_LVL2 = 8'h20;
    localparam logic [7:0] ALS_IDX_LVL3 = 8'h21;
    localparam logic [7:0] ALS_IDX_HOUT = 8'h22;
    localparam logic [7:0] ALS_IDX_MODE = 8'h23;
    localparam logic [7:0] ALS_IDX_STATUS = 8'h24;
    localparam logic [7:0] ALS_IDX_IRQ_STAT = 8'h25;
    localparam logic [7:0] ALS_IDX_IRQ_MASK = 8'h26;

    // reset values
    localparam logic [7:0] ALS_RST_BYTE = 8'h00;
    localparam logic [3:0] ALS_RST_MODE = 4'h0;
    localparam logic [2:0] ALS_RST_IRQ = 3'h0;

    // field positions
    localparam int ALS_ALM_SEL_LSB = 5;
    localparam int ALS_LVL_SEL_LSB = 6;
    localparam int ALS_MODE_ALARM = 0;
    localparam int ALS_MODE_LEVEL = 1;
    localparam int ALS_MODE_CLOOP = 2;
    localparam int ALS_MODE_VOUT = 3;
    localparam int ALS_IRQ_LOW = 0;
    localparam int ALS_IRQ_HIGH = 1;
    localparam int ALS_IRQ_LVL = 2;
    localparam int ALS_IRQ_W = 3;

    // monitored quantity codes
    typedef enum logic [2:0] {
        ALS_SRC_TEMP = 3'h0,
        ALS_SRC_IAMP = 3'h1,
        ALS_SRC_GAIN = 3'h2,
        ALS_SRC_VOUT = 3'h3,
        ALS_SRC_LINE_A = 3'h4,
        ALS_SRC_LINE_B = 3'h5
    } als_src_t;

    // internal conditioned quantities
    typedef struct packed {
        logic [ALS_DW-1:0] temperature_output;
        logic [ALS_DW-1:0] instr_amp_output;
        logic [ALS_DW-1:0] gain_stage_output;
        logic [ALS_DW-1:0] voltage_output;
    } als_quant_t;

    // three shared threshold bytes
    typedef struct packed {
        logic [ALS_DW-1:0] lvl1;
        logic [ALS_DW-1:0] lvl2;
        logic [ALS_DW-1:0] lvl3;
    } als_thr_t;

endpackage
`default_nettype wire

// ===== logic/als_threshold_eval.sv
`timescale 1ns/1ps
`default_nettype none
module als_threshold_eval #(
    parameter int W = 8
) (
    input wire logic [W-1:0] value_i,
    input wire als_pkg::als_thr_t thr_i,
    output logic [1:0] code_o,
    output logic below_o,
    output logic above_o
);

    // four compares serve both modes since the bytes are shared
    always_comb begin
        below_o = (value_i < thr_i.lvl1);
        above_o = (value_i > thr_i.lvl3);
        if (below_o) begin
            code_o = 2'h0;
        end else if (value_i < thr_i.lvl2) begin
            code_o = 2'h1;
        end else if (value_i < thr_i.lvl3) begin
            code_o = 2'h2;
        end else begin
            code_o = 2'h3;
        end
    end

endmodule
`default_nettype wire

// ===== logic/als_alarm_level.sv
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - alarm mode picks one of six quantities
// - level mode picks one of four quantities
// - selector and thresholds shared between modes
// - both outputs enabled keeps alarm off
// - low alarm when value below trigger
// - low alarm forces low substitute byte
// - high alarm when value above trigger
// - high alarm forces high substitute byte
// - first byte marks code 00 to 01
// - second byte marks code 01 to 10
// - third byte marks code 10 to 11
// - level mode wins over alarm mode
// - alarm source from top three bits
module als_alarm_level (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire als_pkg::als_quant_t quant_i,
    input wire logic [als_pkg::ALS_DW-1:0] line_a_value_i,
    input wire logic [als_pkg::ALS_DW-1:0] line_b_value_i,
    input wire logic [als_pkg::ALS_DW-1:0] conditioned_word_i,
    output logic [als_pkg::ALS_DW-1:0] digital_output_word_o,
    output logic alarm_low_o,
    output logic alarm_high_o,
    output logic level_line_a_o,
    output logic level_line_a_oe_o,
    output logic level_line_b_o,
    output logic level_line_b_oe_o,
    output logic irq_o
);

    localparam int DW = als_pkg::ALS_DW;

    logic [7:0] sel_reg;
    logic [7:0] lvl1_reg;
    logic [7:0] lvl2_reg;
    logic [7:0] lvl3_reg;
    logic [7:0] hout_reg;
    logic [3:0] mode_reg;
    logic [als_pkg::ALS_IRQ_W-1:0] irq_stat_reg;
    logic [als_pkg::ALS_IRQ_W-1:0] irq_stat_next;
    logic [als_pkg::ALS_IRQ_W-1:0] irq_mask_reg;
    logic [als_pkg::ALS_IRQ_W-1:0] irq_ev;
    logic [als_pkg::ALS_IRQ_W-1:0] irq_clr;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_idx_reg;
    logic addr_ok_reg;
    logic [1:0] code_reg;
    logic [31:0] rd_mux;
    logic ahb_take;
    logic level_mode;
    logic alarm_mode;
    logic [2:0] src_idx;
    logic src_ok;
    logic [DW-1:0] mon_val;
    logic [1:0] code_c;
    logic below_c;
    logic above_c;
    logic alm_low_c;
    logic alm_high_c;
    als_pkg::als_thr_t thr;

    // register index match, used by both the write and the read decode
    function automatic logic reg_hit(input logic ok, input logic [7:0] a, input logic [7:0] idx);
        reg_hit = ok && (a == idx);
    endfunction

    // one transfer is accepted per address phase that the bus offers
    assign ahb_take = hsel_i && hready_i && htrans_i[1];

    // address phase capture; reads stall one cycle so a write just before is seen
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_idx_reg <= 8'h00;
            addr_ok_reg <= 1'b0;
        end else begin
            wr_pend_reg <= ahb_take && hwrite_i;
            rd_pend_reg <= ahb_take && !hwrite_i;
            if (ahb_take) begin
                addr_idx_reg <= haddr_i[9:2];
                addr_ok_reg <= (haddr_i[31:10] == 22'h000000);
            end
        end
    end

    // read answer: hreadyout low in the first data cycle, data with it high next
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hreadyout_o <= 1'b1;
            hrdata_o <= 32'h00000000;
            hresp_o <= 1'b0;
        end else begin
            hresp_o <= 1'b0;
            if (ahb_take && !hwrite_i) begin
                hreadyout_o <= 1'b0;
            end else if (rd_pend_reg) begin
                hreadyout_o <= 1'b1;
                hrdata_o <= rd_mux;
            end
        end
    end

    // read decode; unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h00000000;
        if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_SELECT)) begin
            rd_mux[7:0] = sel_reg;
        end else if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_LVL1)) begin
            rd_mux[7:0] = lvl1_reg;
        end else if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_LVL2)) begin
            rd_mux[7:0] = lvl2_reg;
        end else if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_LVL3)) begin
            rd_mux[7:0] = lvl3_reg;
        end else if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_HOUT)) begin
            rd_mux[7:0] = hout_reg;
        end else if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_MODE)) begin
            rd_mux[3:0] = mode_reg;
        end else if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_STATUS)) begin
            rd_mux[15:0] = {digital_output_word_o, 2'h0, level_mode, alarm_mode,
                            alarm_high_o, alarm_low_o, code_reg};
        end else if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_IRQ_STAT)) begin
            rd_mux[als_pkg::ALS_IRQ_W-1:0] = irq_stat_reg;
        end else if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_IRQ_MASK)) begin
            rd_mux[als_pkg::ALS_IRQ_W-1:0] = irq_mask_reg;
        end
    end

    // configuration writes land in the data phase; only the low byte is used
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sel_reg <= als_pkg::ALS_RST_BYTE;
            lvl1_reg <= als_pkg::ALS_RST_BYTE;
            lvl2_reg <= als_pkg::ALS_RST_BYTE;
            lvl3_reg <= als_pkg::ALS_RST_BYTE;
            hout_reg <= als_pkg::ALS_RST_BYTE;
            mode_reg <= als_pkg::ALS_RST_MODE;
            irq_mask_reg <= als_pkg::ALS_RST_IRQ;
        end else if (wr_pend_reg) begin
            if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_SELECT)) sel_reg <= hwdata_i[7:0];
            if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_LVL1)) lvl1_reg <= hwdata_i[7:0];
            if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_LVL2)) lvl2_reg <= hwdata_i[7:0];
            if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_LVL3)) lvl3_reg <= hwdata_i[7:0];
            if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_HOUT)) hout_reg <= hwdata_i[7:0];
            if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_MODE)) mode_reg <= hwdata_i[3:0];
            if (reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_IRQ_MASK)) begin
                irq_mask_reg <= hwdata_i[als_pkg::ALS_IRQ_W-1:0];
            end
        end
    end

    assign level_mode = mode_reg[als_pkg::ALS_MODE_LEVEL];
    // current loop plus voltage output inhibits the alarm
    assign alarm_mode = mode_reg[als_pkg::ALS_MODE_ALARM] && !level_mode
                        && !(mode_reg[als_pkg::ALS_MODE_CLOOP] && mode_reg[als_pkg::ALS_MODE_VOUT]);

    // alarm source in the top three selector bits
    // level source in the top two bits, only the four quantities
    assign src_idx = level_mode ? {1'b0, sel_reg[als_pkg::ALS_LVL_SEL_LSB +: 2]}
                                : sel_reg[als_pkg::ALS_ALM_SEL_LSB +: 3];
    // codes six and seven name nothing, so they never raise an alarm
    assign src_ok = (src_idx <= 3'(als_pkg::ALS_SRC_LINE_B));

    always_comb begin
        case (als_pkg::als_src_t'(src_idx))
            als_pkg::ALS_SRC_TEMP: mon_val = quant_i.temperature_output;
            als_pkg::ALS_SRC_IAMP: mon_val = quant_i.instr_amp_output;
            als_pkg::ALS_SRC_GAIN: mon_val = quant_i.gain_stage_output;
            als_pkg::ALS_SRC_VOUT: mon_val = quant_i.voltage_output;
            als_pkg::ALS_SRC_LINE_A: mon_val = line_a_value_i;
            als_pkg::ALS_SRC_LINE_B: mon_val = line_b_value_i;
            default: mon_val = '0;
        endcase
    end

    // the same three bytes act as triggers or as level boundaries
    assign thr = '{lvl1: lvl1_reg, lvl2: lvl2_reg, lvl3: lvl3_reg};

    als_threshold_eval #(
        .W(DW)
    ) u_eval (
        .value_i(mon_val),
        .thr_i(thr),
        .code_o(code_c),
        .below_o(below_c),
        .above_o(above_c)
    );

    assign alm_low_c = alarm_mode && src_ok && below_c;
    // high condition; low wins if the triggers are crossed over
    assign alm_high_c = alarm_mode && src_ok && above_c && !below_c;

    // alarm flags and the forced output word, all from flops
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alarm_low_o <= 1'b0;
            alarm_high_o <= 1'b0;
            digital_output_word_o <= '0;
        end else begin
            alarm_low_o <= alm_low_c;
            alarm_high_o <= alm_high_c;
            if (alm_low_c) begin
                // low substitute shares the second level byte
                digital_output_word_o <= lvl2_reg;
            end else if (alm_high_c) begin
                digital_output_word_o <= hout_reg;
            end else begin
                digital_output_word_o <= conditioned_word_i;
            end
        end
    end

    // level lines are driven only in level mode, released for the monitor otherwise
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            code_reg <= 2'h0;
            level_line_a_o <= 1'b0;
            level_line_b_o <= 1'b0;
            level_line_a_oe_o <= 1'b0;
            level_line_b_oe_o <= 1'b0;
        end else begin
            code_reg <= level_mode ? code_c : 2'h0;
            level_line_a_o <= level_mode && code_c[0];
            level_line_b_o <= level_mode && code_c[1];
            level_line_a_oe_o <= level_mode;
            level_line_b_oe_o <= level_mode;
        end
    end

    // events: alarm entry and level code change; write one clears, set wins
    always_comb begin
        irq_ev = '0;
        irq_ev[als_pkg::ALS_IRQ_LOW] = alm_low_c && !alarm_low_o;
        irq_ev[als_pkg::ALS_IRQ_HIGH] = alm_high_c && !alarm_high_o;
        irq_ev[als_pkg::ALS_IRQ_LVL] = level_mode && (code_c != code_reg);
        irq_clr = '0;
        if (wr_pend_reg && reg_hit(addr_ok_reg, addr_idx_reg, als_pkg::ALS_IDX_IRQ_STAT)) begin
            irq_clr = hwdata_i[als_pkg::ALS_IRQ_W-1:0];
        end
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;
    end

    // sticky status and the masked interrupt level
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_stat_reg <= als_pkg::ALS_RST_IRQ;
            irq_o <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // read handshake as two steps
    sequence seq_rd_addr;
        ahb_take && !hwrite_i;
    endsequence
    sequence seq_rd_answer;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    chk_read_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        seq_rd_addr |=> seq_rd_answer)
        else $error("read answer not after exactly one wait cycle");

    chk_cloop_inhibit: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (mode_reg[als_pkg::ALS_MODE_CLOOP] && mode_reg[als_pkg::ALS_MODE_VOUT])
        |=> (!alarm_low_o && !alarm_high_o))
        else $error("alarm raised with both outputs enabled");

    chk_level_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        level_mode |=> (!alarm_low_o && !alarm_high_o && level_line_a_oe_o))
        else $error("alarm active while level mode selected");

    chk_low_alarm: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (alarm_mode && src_ok && mon_val < lvl1_reg) |=> alarm_low_o)
        else $error("low alarm missing below trigger");

    chk_low_word: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        alm_low_c |=> (digital_output_word_o == $past(lvl2_reg)))
        else $error("low substitute not driven");

    chk_high_alarm: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (alarm_mode && src_ok && mon_val > lvl3_reg && mon_val >= lvl1_reg) |=> alarm_high_o)
        else $error("high alarm missing above trigger");

    chk_high_word: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        alarm_high_o |-> (digital_output_word_o == $past(hout_reg)))
        else $error("high substitute not driven");

    chk_code_low: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (level_mode && mon_val < lvl1_reg) |=> (code_reg == 2'h0 && !level_line_a_o))
        else $error("code not 00 below first level");

    chk_code_mid: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (level_mode && mon_val >= lvl1_reg && mon_val < lvl2_reg) |=> (code_reg == 2'h1))
        else $error("code not 01 between first and second level");

    chk_code_top: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (level_mode && mon_val >= lvl1_reg && mon_val >= lvl2_reg && mon_val >= lvl3_reg)
        |=> (level_line_a_o && level_line_b_o))
        else $error("code not 11 at or above third level");

    chk_pass_word: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (!alm_low_c && !alm_high_c) |=> (digital_output_word_o == $past(conditioned_word_i)))
        else $error("conditioned word not passed through");

    chk_irq_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (irq_ev != '0) |=> ((irq_stat_reg & $past(irq_ev)) == $past(irq_ev)))
        else $error("event lost from sticky status");

endmodule
`default_nettype wire

// ===== sim/als_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module als_far_side (
    input wire logic clk_sys_i,
    input wire logic line_a_i,
    input wire logic line_a_oe_i,
    input wire logic line_b_i,
    input wire logic line_b_oe_i,
    output var als_pkg::als_quant_t quant_o,
    output logic [7:0] line_a_value_o,
    output logic [7:0] line_b_value_o,
    output logic [7:0] cond_o,
    output logic [1:0] code_o
);
    logic [1:0] last_reg = 2'h0;

    // remember the last driven level of each line
    always_ff @(posedge clk_sys_i) begin
        if (line_a_oe_i) begin
            last_reg[0] <= line_a_i;
        end
        if (line_b_oe_i) begin
            last_reg[1] <= line_b_i;
        end
    end

    // no pull on the lines: a released line shows the inverse of its last level
    always_comb begin
        code_o[0] = line_a_oe_i ? line_a_i : ~last_reg[0];
        code_o[1] = line_b_oe_i ? line_b_i : ~last_reg[1];
    end

    // idle quantities sit between the trigger levels
    initial begin
        quant_o <= {4{8'h80}};
        line_a_value_o <= 8'h80;
        line_b_value_o <= 8'h80;
        cond_o <= 8'h5C;
    end

    // one quantity takes the probe value, all others stay mid-range
    task automatic set_src(input int s, input logic [7:0] v, input logic [7:0] c);
        @(posedge clk_sys_i);
        quant_o <= {(s == 0) ? v : 8'h80, (s == 1) ? v : 8'h80,
                    (s == 2) ? v : 8'h80, (s == 3) ? v : 8'h80};
        line_a_value_o <= (s == 4) ? v : 8'h80;
        line_b_value_o <= (s == 5) ? v : 8'h80;
        cond_o <= c;
    endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_i, rst_b_i, hsel, hwrite, hready, hresp;
    logic [1:0] htrans, code_w;
    logic [31:0] haddr, hwdata, hrdata, x;
    als_pkg::als_quant_t quant;
    logic [7:0] line_a, line_b, cond, dout;
    logic alm_lo, alm_hi, la, la_oe, lb, lb_oe, irq;
    logic [7:0] vals [4] = '{8'h3F, 8'h40, 8'h80, 8'hC0};
    int error_cnt, checks_done;

    als_alarm_level i_dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .quant_i(quant), .line_a_value_i(line_a), .line_b_value_i(line_b),
        .conditioned_word_i(cond), .digital_output_word_o(dout), .alarm_low_o(alm_lo),
        .alarm_high_o(alm_hi), .level_line_a_o(la), .level_line_a_oe_o(la_oe),
        .level_line_b_o(lb), .level_line_b_oe_o(lb_oe), .irq_o(irq)
    );

    als_far_side i_far (
        .clk_sys_i(clk_sys_i), .line_a_i(la), .line_a_oe_i(la_oe), .line_b_i(lb),
        .line_b_oe_i(lb_oe), .quant_o(quant), .line_a_value_o(line_a),
        .line_b_value_o(line_b), .cond_o(cond), .code_o(code_w)
    );

    // 200 MHz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one single transfer; entered just after a rising edge, waits on hready only
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk_sys_i);
        while (hready !== 1'b1) @(posedge clk_sys_i);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys_i);
        while (hready !== 1'b1) @(posedge clk_sys_i);
        rd = hrdata;
    endtask

    function automatic logic [31:0] ba(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction

    task automatic wreg(input logic [7:0] i, input logic [31:0] d);
        bus(1'b1, ba(i), d, x);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, x);
        chk($sformatf("reg %h", a), e, x);
        // the slave only ever answers OKAY
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // outputs are registered: give the path three edges to settle
    task automatic outchk(input logic [7:0] o, input logic lo, input logic hi,
                          input logic lv, input logic [1:0] c);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("out", {o, lo, hi, lv, lv}, {dout, alm_lo, alm_hi, la_oe, lb_oe});
        if (lv) begin
            chk("code", c, code_w);
        end
        @(posedge clk_sys_i);
    endtask

    // irq follows its status one cycle late
    task automatic ichk(input logic e);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("irq", e, irq);
        @(posedge clk_sys_i);
    endtask

    initial begin
        rst_b_i <= 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} <= '0;
        error_cnt = 0;
        checks_done = 0;
        repeat (20) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        // reset values; status shows the passed-through word
        for (int i = 0; i < 9; i++) begin
            rchk(ba(als_pkg::ALS_IDX_SELECT + 8'(i)), (i == 6) ? 32'h5C00 : 32'h0);
        end
        // upper data bits drop, upper address bits and unmapped places are ignored
        wreg(als_pkg::ALS_IDX_SELECT, 32'hFFFFFF5A);
        bus(1'b1, 32'h400 | ba(als_pkg::ALS_IDX_SELECT), 32'h33, x);
        rchk(ba(als_pkg::ALS_IDX_SELECT), 32'h5A);
        rchk(32'h400 | ba(als_pkg::ALS_IDX_SELECT), 32'h0);
        rchk(ba(8'h27), 32'h0);
        wreg(als_pkg::ALS_IDX_LVL1, 32'h40);
        wreg(als_pkg::ALS_IDX_LVL2, 32'h11);
        wreg(als_pkg::ALS_IDX_LVL3, 32'hC0);
        wreg(als_pkg::ALS_IDX_HOUT, 32'hEE);
        rchk(ba(als_pkg::ALS_IDX_HOUT), 32'hEE);
        wreg(als_pkg::ALS_IDX_MODE, 32'h1);
        // every alarm source at both edges of both triggers
        for (int s = 0; s < 6; s++) begin
            wreg(als_pkg::ALS_IDX_SELECT, 32'(s) << 5);
            i_far.set_src(s, 8'h3F, 8'h5C);
            outchk(8'h11, 1'b1, 1'b0, 1'b0, 2'h0);
            i_far.set_src(s, 8'h40, 8'h5C);
            outchk(8'h5C, 1'b0, 1'b0, 1'b0, 2'h0);
            i_far.set_src(s, 8'hC1, 8'h5C);
            outchk(8'hEE, 1'b0, 1'b1, 1'b0, 2'h0);
            i_far.set_src(s, 8'hC0, 8'h5C);
            outchk(8'h5C, 1'b0, 1'b0, 1'b0, 2'h0);
        end
        // codes six and seven name no quantity; a missing guard would read zero and alarm
        for (int s = 6; s < 8; s++) begin
            wreg(als_pkg::ALS_IDX_SELECT, 32'(s) << 5);
            outchk(8'h5C, 1'b0, 1'b0, 1'b0, 2'h0);
        end
        wreg(als_pkg::ALS_IDX_SELECT, 32'h0);
        i_far.set_src(0, 8'h3F, 8'h5C);
        outchk(8'h11, 1'b1, 1'b0, 1'b0, 2'h0);
        rchk(ba(als_pkg::ALS_IDX_STATUS), 32'h1114);
        // interrupt: clear, entry, mask, clear while condition persists
        wreg(als_pkg::ALS_IDX_IRQ_STAT, 32'h7);
        rchk(ba(als_pkg::ALS_IDX_IRQ_STAT), 32'h0);
        i_far.set_src(0, 8'h80, 8'h5C);
        outchk(8'h5C, 1'b0, 1'b0, 1'b0, 2'h0);
        i_far.set_src(0, 8'h3F, 8'h5C);
        outchk(8'h11, 1'b1, 1'b0, 1'b0, 2'h0);
        rchk(ba(als_pkg::ALS_IDX_IRQ_STAT), 32'h1);
        ichk(1'b0);
        wreg(als_pkg::ALS_IDX_IRQ_MASK, 32'h1);
        ichk(1'b1);
        wreg(als_pkg::ALS_IDX_IRQ_STAT, 32'h1);
        ichk(1'b0);
        i_far.set_src(0, 8'hC1, 8'h5C);
        outchk(8'hEE, 1'b0, 1'b1, 1'b0, 2'h0);
        rchk(ba(als_pkg::ALS_IDX_IRQ_STAT), 32'h2);
        ichk(1'b0);
        wreg(als_pkg::ALS_IDX_IRQ_MASK, 32'h2);
        ichk(1'b1);
        // both analog outputs enabled keeps the alarm off
        i_far.set_src(0, 8'h3F, 8'h5C);
        wreg(als_pkg::ALS_IDX_MODE, 32'hD);
        outchk(8'h5C, 1'b0, 1'b0, 1'b0, 2'h0);
        rchk(ba(als_pkg::ALS_IDX_STATUS), 32'h5C00);
        wreg(als_pkg::ALS_IDX_MODE, 32'h5);
        outchk(8'h11, 1'b1, 1'b0, 1'b0, 2'h0);
        // both modes on: level steering wins, same threshold bytes reused
        wreg(als_pkg::ALS_IDX_LVL2, 32'h80);
        wreg(als_pkg::ALS_IDX_MODE, 32'h3);
        for (int s = 0; s < 4; s++) begin
            wreg(als_pkg::ALS_IDX_SELECT, 32'(s) << 6);
            for (int k = 0; k < 4; k++) begin
                i_far.set_src(s, vals[k], 8'h5C);
                outchk(8'h5C, 1'b0, 1'b0, 1'b1, 2'(k));
            end
        end
        // status shows level mode active with code 11; every event kind has been seen
        rchk(ba(als_pkg::ALS_IDX_STATUS), 32'h5C23);
        rchk(ba(als_pkg::ALS_IDX_IRQ_STAT), 32'h7);
        complete_run();
    end

    // far longer than the sequence above needs
    initial begin
        #200000;
        error_cnt++;
        $display("ERROR watchdog expired");
        complete_run();
    end
endmodule
`default_nettype wire
